// ==== src/trailer_level_ctrl.sv ====
/*
 * Level, lift-axle, overload and traction-help control of a trailer
 * air-suspension unit, with its parameter registers on a plain port.
 * Assumes sensor and command pins are asynchronous to clk and that the
 * configuration tool writes the parameters over the register port.
 */
`timescale 1ns/1ns
module trailer_level_ctrl
    import trailer_level_pkg::*;
#(
    parameter int QUARTER_CYCLES_P = QUARTER_CYCLES,
    parameter int PULSE_STEP_CYCLES_P = PULSE_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [DATA_W-1:0] regRdData,
    // Sensor pins
    input wire logic [7:0] heightIn,
    input wire logic [7:0] pressureIn,
    input wire logic [7:0] speedIn,
    // Command pins
    input wire logic manualLowerIn,
    input wire logic manualRaiseIn,
    input wire logic manual2LowerIn,
    input wire logic manual2RaiseIn,
    input wire logic tractionReqIn,
    // Actuators and status
    output logic valveRaise,
    output logic valveLower,
    output logic liftAxleDown,
    output logic lift2AxleDown,
    output logic onBuffers,
    output logic tractionActive,
    output logic [7:0] targetLevel
);

    // Two-flop synchronisers for every pin input
    localparam int SYNC_W = 29;
    logic [SYNC_W-1:0] syncA_ff, syncB_ff;
    logic [4:0] prevCmd_ff;
    wire logic [SYNC_W-1:0] pinVec = {heightIn, pressureIn, speedIn, manualLowerIn, manualRaiseIn,
                                       manual2LowerIn, manual2RaiseIn, tractionReqIn};
    wire logic [7:0] height = syncB_ff[28:21];
    wire logic [7:0] pressure = syncB_ff[20:13];
    wire logic [7:0] speed = syncB_ff[12:5];
    wire logic [4:0] cmdRise = syncB_ff[4:0] & ~prevCmd_ff;

    always_ff @(posedge clk) begin
        syncA_ff <= pinVec;
        syncB_ff <= syncA_ff;
        prevCmd_ff <= syncB_ff[4:0];
    end

    // Parameter registers
    logic [7:0] options_ff, levelOne_ff, offset_ff, speedUp_ff, speedDown_ff, motionDelay_ff;
    logic [7:0] lowerP_ff, raiseP_ff, overP_ff, manualSpeed_ff, tracHome_ff, tracOther_ff;
    logic [7:0] kd_ff, period_ff, secondSpeed_ff;

    wire logic wrOptions = regWrStrobe && regAddr == REG_OPTIONS;
    wire logic wrLevelOne = regWrStrobe && regAddr == REG_LEVEL_ONE;
    wire logic wrOffset = regWrStrobe && regAddr == REG_LEVEL_TWO_OFFSET;
    wire logic wrSpeedUp = regWrStrobe && regAddr == REG_SPEED_UPPER;
    wire logic wrSpeedDown = regWrStrobe && regAddr == REG_SPEED_LOWER;
    wire logic wrDelay = regWrStrobe && regAddr == REG_MOTION_DELAY;
    wire logic wrLowerP = regWrStrobe && regAddr == REG_LOWERING_PRESSURE;
    wire logic wrRaiseP = regWrStrobe && regAddr == REG_RAISING_PRESSURE;
    wire logic wrOverP = regWrStrobe && regAddr == REG_OVER_PRESSURE;
    wire logic wrManual = regWrStrobe && regAddr == REG_MANUAL_SPEED;
    wire logic wrTracHome = regWrStrobe && regAddr == REG_TRACTION_HOME;
    wire logic wrTracOther = regWrStrobe && regAddr == REG_TRACTION_OTHER;
    wire logic wrKd = regWrStrobe && regAddr == REG_DERIVATIVE;
    wire logic wrPeriod = regWrStrobe && regAddr == REG_PULSE_PERIOD;
    wire logic wrSecond = regWrStrobe && regAddr == REG_SECOND_AXLE_SPEED;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            options_ff <= RST_OPTIONS;
            levelOne_ff <= RST_LEVEL_ONE;
            offset_ff <= RST_LEVEL_TWO_OFFSET;
            speedUp_ff <= RST_SPEED_UPPER;
            speedDown_ff <= RST_SPEED_LOWER;
            motionDelay_ff <= RST_MOTION_DELAY;
            lowerP_ff <= RST_LOWERING_PRESSURE;
            raiseP_ff <= RST_RAISING_PRESSURE;
            overP_ff <= RST_OVER_PRESSURE;
            manualSpeed_ff <= RST_MANUAL_SPEED;
            tracHome_ff <= RST_TRACTION;
            tracOther_ff <= RST_TRACTION;
            kd_ff <= RST_DERIVATIVE;
            period_ff <= RST_PULSE_PERIOD;
            secondSpeed_ff <= RST_MANUAL_SPEED;
        end else begin
            if (wrOptions) options_ff <= regWrData;
            if (wrLevelOne) levelOne_ff <= regWrData;
            if (wrOffset) offset_ff <= regWrData;
            if (wrSpeedUp) speedUp_ff <= regWrData;
            if (wrSpeedDown) speedDown_ff <= regWrData;
            if (wrDelay) motionDelay_ff <= regWrData;
            if (wrLowerP) lowerP_ff <= regWrData;
            if (wrRaiseP) raiseP_ff <= regWrData;
            if (wrOverP) overP_ff <= regWrData;
            if (wrManual) manualSpeed_ff <= regWrData;
            if (wrTracHome) tracHome_ff <= regWrData;
            if (wrTracOther) tracOther_ff <= regWrData;
            if (wrKd) kd_ff <= regWrData;
            if (wrPeriod) period_ff <= regWrData;
            if (wrSecond) secondSpeed_ff <= regWrData;
        end
    end

    // Prescalers: quarter second and pulse step
    logic [22:0] quarterCnt_ff, stepCnt_ff;
    wire logic quarterTick = quarterCnt_ff == 23'(QUARTER_CYCLES_P - 1);
    wire logic stepTick = stepCnt_ff == 23'(PULSE_STEP_CYCLES_P - 1);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            quarterCnt_ff <= '0;
            stepCnt_ff <= '0;
        end else begin
            quarterCnt_ff <= quarterTick ? '0 : quarterCnt_ff + 23'h1;
            stepCnt_ff <= stepTick ? '0 : stepCnt_ff + 23'h1;
        end
    end

    // Driving level two from level one and the coded offset
    wire logic offsetUp = offset_ff <= OFFSET_UP_MAX;
    wire logic offsetDown = offset_ff > OFFSET_DOWN_BASE;
    wire logic [7:0] levelTwo = offsetUp ? levelOne_ff + offset_ff :
                                offsetDown ? levelOne_ff - (offset_ff - OFFSET_DOWN_BASE) : levelOne_ff;

    // Speed-dependent level choice with hysteresis
    logic useLevelTwo_ff;
    wire logic speedLevelOn = !options_ff[OPT_NO_SPEED_LEVEL];
    wire logic [7:0] nxt_target = useLevelTwo_ff ? levelTwo : levelOne_ff;

    always_ff @(posedge clk) begin
        if (sys_rst || !speedLevelOn) begin
            useLevelTwo_ff <= 1'b0;
        end else if (speed > speedUp_ff) begin
            useLevelTwo_ff <= 1'b1;
        end else if (speed < speedDown_ff) begin
            useLevelTwo_ff <= 1'b0;
        end
    end

    // In-motion control interval; the raw setting stays readable
    wire logic [7:0] motionDelayUsed = motionDelay_ff < MOTION_DELAY_MIN ? MOTION_DELAY_MIN
                                                                          : motionDelay_ff;
    logic [7:0] motionCnt_ff;
    wire logic moving = speed != 8'h00;
    wire logic controlDue = moving && quarterTick && motionCnt_ff + 8'h1 >= motionDelayUsed;

    always_ff @(posedge clk) begin
        if (sys_rst || !moving) begin
            motionCnt_ff <= 8'h00;
        end else if (quarterTick) begin
            motionCnt_ff <= controlDue ? 8'h00 : motionCnt_ff + 8'h1;
        end
    end

    // Valve time per control event, in pulse steps
    logic [7:0] prevHeight_ff, valveTime_ff, pulseLeft_ff;
    wire logic below = height < nxt_target;
    wire logic above = height > nxt_target;
    wire logic [7:0] errMag = below ? nxt_target - height : height - nxt_target;
    wire logic [7:0] rise = height > prevHeight_ff ? height - prevHeight_ff : 8'h00;
    // Full 16-bit product before the divide by three keeps small rates
    wire logic [15:0] shorten = 16'((16'(kd_ff) * 16'(rise)) / 16'h3);
    wire logic [7:0] rawTime = errMag >= period_ff ? period_ff : errMag;
    wire logic [7:0] raiseTime = 16'(rawTime) > shorten ? rawTime - shorten[7:0] : 8'h00;
    wire logic [7:0] nxt_valveTime = below ? raiseTime : rawTime;

    // Overpressure latch; no clear path, only sys_rst releases it
    logic overLatch_ff;
    wire logic overEvent = pressure > overP_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overLatch_ff <= 1'b0;
        end else if (overEvent) begin
            overLatch_ff <= 1'b1;
        end
    end

    // Valve drive; a time at full period energises the valve for period_ff pulse steps
    logic raising_ff;
    wire logic pulseOn = pulseLeft_ff != 8'h00;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prevHeight_ff <= 8'h00;
            valveTime_ff <= 8'h00;
            pulseLeft_ff <= 8'h00;
            raising_ff <= 1'b0;
        end else if (controlDue && !overLatch_ff) begin
            prevHeight_ff <= height;
            valveTime_ff <= nxt_valveTime;
            pulseLeft_ff <= (below || above) ? nxt_valveTime : 8'h00;
            raising_ff <= below;
        end else begin
            // Rate reference follows the body while stopped, so the
            // first event after standstill, or after a reset released at standstill, sees no false climb
            if (!moving) prevHeight_ff <= height;
            if (stepTick && pulseOn) pulseLeft_ff <= pulseLeft_ff - 8'h1;
        end
    end

    // Lift axles
    logic lift1_ff, lift2_ff, tracOn_ff;
    wire logic fullAuto = options_ff[OPT_FULL_AUTO_LIFT];
    wire logic manualOk = fullAuto || speed <= manualSpeed_ff;
    // Second axle limit is taken relative to the first axle's limit
    wire logic [8:0] secondLimit = 9'(manualSpeed_ff) + 9'(secondSpeed_ff);
    wire logic manual2Ok = fullAuto || 9'(speed) <= secondLimit;
    wire logic autoLower = pressure > lowerP_ff;
    wire logic autoRaise = pressure < raiseP_ff;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lift1_ff <= 1'b0;
            lift2_ff <= 1'b0;
        end else if (overLatch_ff || autoLower) begin
            lift1_ff <= 1'b1;
            lift2_ff <= 1'b1;
        end else if (tracOn_ff) begin
            lift1_ff <= 1'b0;
            lift2_ff <= 1'b0;
        end else begin
            if (autoRaise) lift1_ff <= 1'b0;
            else if (manualOk && cmdRise[4]) lift1_ff <= 1'b1;
            else if (manualOk && cmdRise[3]) lift1_ff <= 1'b0;
            if (manual2Ok && cmdRise[2]) lift2_ff <= 1'b1;
            else if (manual2Ok && cmdRise[1]) lift2_ff <= 1'b0;
        end
    end

    // Traction help duration in five-second steps
    wire logic [1:0] tracSel = {options_ff[OPT_TRACTION_OTHER], options_ff[OPT_TRACTION_HOME]};
    wire logic [7:0] tracLimit = tracSel == 2'b10 ? tracOther_ff : tracHome_ff;
    wire logic tracEnabled = tracSel == 2'b01 || tracSel == 2'b10;
    logic [4:0] fiveSub_ff;
    logic [7:0] tracCnt_ff;
    wire logic fiveTick = quarterTick && fiveSub_ff == 5'(TRACTION_QUARTERS - 1);
    wire logic tracEnd = tracLimit != TRACTION_ENDLESS && fiveTick && tracCnt_ff + 8'h1 >= tracLimit;

    always_ff @(posedge clk) begin
        if (sys_rst || !tracOn_ff) begin
            fiveSub_ff <= 5'h00;
        end else if (quarterTick) begin
            fiveSub_ff <= fiveTick ? 5'h00 : fiveSub_ff + 5'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tracOn_ff <= 1'b0;
            tracCnt_ff <= 8'h00;
        end else if (!tracOn_ff) begin
            tracOn_ff <= tracEnabled && cmdRise[0] && !overLatch_ff;
            tracCnt_ff <= 8'h00;
        end else if (tracEnd || overLatch_ff || !tracEnabled) begin
            tracOn_ff <= 1'b0;
        end else if (fiveTick) begin
            tracCnt_ff <= tracCnt_ff + 8'h1;
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            valveRaise <= 1'b0;
            valveLower <= 1'b0;
            liftAxleDown <= 1'b0;
            lift2AxleDown <= 1'b0;
            onBuffers <= 1'b0;
            tractionActive <= 1'b0;
            targetLevel <= 8'h00;
        end else begin
            valveRaise <= pulseOn && raising_ff && !overLatch_ff;
            valveLower <= overLatch_ff || (pulseOn && !raising_ff);
            liftAxleDown <= lift1_ff;
            lift2AxleDown <= lift2_ff;
            onBuffers <= overLatch_ff;
            tractionActive <= tracOn_ff;
            targetLevel <= nxt_target;
        end
    end

    // Read path; unmapped addresses read zero
    wire logic [7:0] statusWord = {2'b00, options_ff[OPT_ALT_SENSOR], manualOk, tracOn_ff, overLatch_ff,
                                   lift1_ff, useLevelTwo_ff};
    logic [7:0] rdMux;

    always_comb begin
        case (regAddr)
            REG_OPTIONS: rdMux = options_ff;
            REG_LEVEL_ONE: rdMux = levelOne_ff;
            REG_LEVEL_TWO_OFFSET: rdMux = offset_ff;
            REG_SPEED_UPPER: rdMux = speedUp_ff;
            REG_SPEED_LOWER: rdMux = speedDown_ff;
            REG_MOTION_DELAY: rdMux = motionDelay_ff;
            REG_LOWERING_PRESSURE: rdMux = lowerP_ff;
            REG_RAISING_PRESSURE: rdMux = raiseP_ff;
            REG_OVER_PRESSURE: rdMux = overP_ff;
            REG_MANUAL_SPEED: rdMux = manualSpeed_ff;
            REG_TRACTION_HOME: rdMux = tracHome_ff;
            REG_TRACTION_OTHER: rdMux = tracOther_ff;
            REG_DERIVATIVE: rdMux = kd_ff;
            REG_PULSE_PERIOD: rdMux = period_ff;
            REG_SECOND_AXLE_SPEED: rdMux = secondSpeed_ff;
            REG_STATUS: rdMux = statusWord;
            REG_TARGET_LEVEL: rdMux = nxt_target;
            REG_VALVE_TIME: rdMux = valveTime_ff;
            default: rdMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= regRdStrobe ? rdMux : 8'h00;
        end
    end

endmodule

// ==== src/trailer_level_pkg.sv ====
/*
 * Constants shared by the trailer air-suspension level logic: register map,
 * option bit positions, reset values and the time-base figures.
 * Assumes a single 20 MHz system clock.
 */
package trailer_level_pkg;

    // Data and address widths of the register port
    localparam int DATA_W = 8;
    localparam int ADDR_W = 5;

    // Register offsets (byte index on the register port)
    localparam logic [4:0] REG_OPTIONS = 5'h00;
    localparam logic [4:0] REG_LEVEL_ONE = 5'h01;
    localparam logic [4:0] REG_LEVEL_TWO_OFFSET = 5'h02;
    localparam logic [4:0] REG_SPEED_UPPER = 5'h03;
    localparam logic [4:0] REG_SPEED_LOWER = 5'h04;
    localparam logic [4:0] REG_MOTION_DELAY = 5'h05;
    localparam logic [4:0] REG_LOWERING_PRESSURE = 5'h06;
    localparam logic [4:0] REG_RAISING_PRESSURE = 5'h07;
    localparam logic [4:0] REG_OVER_PRESSURE = 5'h08;
    localparam logic [4:0] REG_MANUAL_SPEED = 5'h09;
    localparam logic [4:0] REG_TRACTION_HOME = 5'h0a;
    localparam logic [4:0] REG_TRACTION_OTHER = 5'h0b;
    localparam logic [4:0] REG_DERIVATIVE = 5'h0c;
    localparam logic [4:0] REG_PULSE_PERIOD = 5'h0d;
    localparam logic [4:0] REG_SECOND_AXLE_SPEED = 5'h0e;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_TARGET_LEVEL = 5'h11;
    localparam logic [4:0] REG_VALVE_TIME = 5'h12;

    // Option register bit positions
    localparam int OPT_TRACTION_HOME = 0;
    localparam int OPT_TRACTION_OTHER = 1;
    localparam int OPT_NO_SPEED_LEVEL = 2;
    localparam int OPT_FULL_AUTO_LIFT = 3;
    localparam int OPT_ALT_SENSOR = 4;

    // Reset values
    localparam logic [7:0] RST_OPTIONS = 8'h00;
    localparam logic [7:0] RST_LEVEL_ONE = 8'h80;
    localparam logic [7:0] RST_LEVEL_TWO_OFFSET = 8'h00;
    localparam logic [7:0] RST_SPEED_UPPER = 8'h32;
    localparam logic [7:0] RST_SPEED_LOWER = 8'h28;
    localparam logic [7:0] RST_MOTION_DELAY = 8'hf0;
    localparam logic [7:0] RST_LOWERING_PRESSURE = 8'hff;
    localparam logic [7:0] RST_RAISING_PRESSURE = 8'h00;
    localparam logic [7:0] RST_OVER_PRESSURE = 8'hff;
    localparam logic [7:0] RST_MANUAL_SPEED = 8'h14;
    localparam logic [7:0] RST_TRACTION = 8'h12;
    localparam logic [7:0] RST_DERIVATIVE = 8'h14;
    localparam logic [7:0] RST_PULSE_PERIOD = 8'h0c;

    // Level-two offset coding
    localparam logic [7:0] OFFSET_UP_MAX = 8'h63;
    localparam logic [7:0] OFFSET_DOWN_BASE = 8'h64;

    // Motion interval floor in quarter seconds (10 s)
    localparam logic [7:0] MOTION_DELAY_MIN = 8'h28;
    // Traction duration value that means unlimited
    localparam logic [7:0] TRACTION_ENDLESS = 8'hff;

    // Time base
    localparam int CLK_HZ = 20_000_000;
    localparam int QUARTER_MS = 250;
    localparam int PULSE_STEP_MS = 25;
    localparam int TRACTION_STEP_S = 5;
    localparam int QUARTER_CYCLES = CLK_HZ / 1000 * QUARTER_MS;
    localparam int PULSE_STEP_CYCLES = CLK_HZ / 1000 * PULSE_STEP_MS;
    localparam int TRACTION_QUARTERS = TRACTION_STEP_S * 1000 / QUARTER_MS;

endpackage

// ==== tb/suspension_plant_model.sv ====
/* Air spring with height sensor: the body height follows the valves.
   Assumes the valve outputs of the control block drive it directly. */
`timescale 1ns/1ns
module suspension_plant_model #(
    parameter logic [7:0] START_HEIGHT = 8'h70
) (
    // Clock
    input wire logic clk,
    // Valves and sensor
    input wire logic valveRaise,
    input wire logic valveLower,
    output logic [7:0] heightIn
);
    logic [1:0] slow_ff = 2'h0;
    logic [7:0] level_ff = START_HEIGHT;

    // Body moves one count every four cycles, once per pulse step
    always @(posedge clk) begin
        slow_ff <= slow_ff + 2'h1;
        if (slow_ff == 2'h3 && valveRaise && level_ff != 8'hff) level_ff <= level_ff + 8'h01;
        if (slow_ff == 2'h3 && valveLower && level_ff != 8'h00) level_ff <= level_ff - 8'h01;
    end

    assign heightIn = level_ff;
endmodule

// ==== tb/trailer_level_ctrl_tb_top.sv ====
/* Self-checking bench for the trailer level control block.
   Assumes shortened prescalers: 10 cycles a quarter second, 4 a pulse step. */
`timescale 1ns/1ns
module trailer_level_ctrl_tb_top;
    import trailer_level_pkg::*;
    localparam int QC = 10;
    localparam int TRAC_CYC = QC * TRACTION_QUARTERS;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic regWrStrobe = 1'b0;
    logic regRdStrobe = 1'b0;
    logic [7:0] pressureIn = 8'h50;
    logic [7:0] speedIn = 8'h00;
    logic [4:0] cmdBits = 5'h00;
    logic [7:0] regRdData, rdVal, targetLevel, heightIn, expLvl;
    logic valveRaise, valveLower, liftAxleDown, lift2AxleDown, onBuffers, tractionActive;
    logic [7:0] rstTab [14] = '{RST_OPTIONS, RST_LEVEL_ONE, RST_LEVEL_TWO_OFFSET, RST_SPEED_UPPER,
        RST_SPEED_LOWER, RST_MOTION_DELAY, RST_LOWERING_PRESSURE, RST_RAISING_PRESSURE, RST_OVER_PRESSURE,
        RST_MANUAL_SPEED, RST_TRACTION, RST_TRACTION, RST_DERIVATIVE, RST_PULSE_PERIOD};
    logic [7:0] offTab [4] = '{8'h05, 8'h63, 8'h64, 8'h6e};
    int n_fail = 0;
    int check_count = 0;
    int i, seen, dur;
    wire [7:0] liftPair = {6'h0, lift2AxleDown, liftAxleDown};

    initial forever #25 clk = ~clk;

    trailer_level_ctrl #(.QUARTER_CYCLES_P(QC), .PULSE_STEP_CYCLES_P(4)) u_trailer_level_ctrl (
        .clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData), .heightIn(heightIn), .pressureIn(pressureIn),
        .speedIn(speedIn), .manualLowerIn(cmdBits[0]), .manualRaiseIn(cmdBits[1]),
        .manual2LowerIn(cmdBits[2]), .manual2RaiseIn(cmdBits[3]), .tractionReqIn(cmdBits[4]),
        .valveRaise(valveRaise), .valveLower(valveLower), .liftAxleDown(liftAxleDown),
        .lift2AxleDown(lift2AxleDown), .onBuffers(onBuffers), .tractionActive(tractionActive),
        .targetLevel(targetLevel));

    suspension_plant_model u_suspension_plant_model (.clk(clk), .valveRaise(valveRaise),
        .valveLower(valveLower), .heightIn(heightIn));

    task automatic conclude();
        if (n_fail == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge clk);
        regWrStrobe <= 1'b0;
    endtask

    // Read data exist only in the cycle after the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge clk);
        regRdStrobe <= 1'b0;
        #1;
        rdVal = regRdData;
    endtask

    task automatic pins(input logic [7:0] p, input logic [7:0] s);
        @(posedge clk);
        pressureIn <= p;
        speedIn <= s;
    endtask

    // Held four cycles so the synchroniser sees a clean edge
    task automatic cmd(input int b);
        @(posedge clk);
        cmdBits[b] <= 1'b1;
        repeat (4) @(posedge clk);
        cmdBits[b] <= 1'b0;
        cyc(4);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(2);
        chk("level after reset", RST_LEVEL_ONE, targetLevel);
        for (i = 0; i < 14; i++) begin
            rd(5'(i));
            chk("reset register", rstTab[i], rdVal);
        end
        rd(5'h1f);
        chk("unmapped read", 8'h00, rdVal);
        wr(REG_TARGET_LEVEL, 8'h11);
        rd(REG_TARGET_LEVEL);
        chk("read-only target", RST_LEVEL_ONE, rdVal);
        // Short delay must read back as written yet act as the floor
        wr(REG_MOTION_DELAY, 8'h0a);
        rd(REG_MOTION_DELAY);
        chk("motion delay readback", 8'h0a, rdVal);
        pins(8'h50, 8'h10);
        seen = 0;
        for (i = 0; i < MOTION_DELAY_MIN * QC - 40; i++) begin
            cyc(1);
            if (valveRaise === 1'b1) seen = 1;
        end
        chk("raise before interval", 8'h00, 8'(seen));
        for (i = 0; i < 120 && valveRaise !== 1'b1; i++) cyc(1);
        chk("raise at interval", 8'h01, {7'h0, valveRaise});
        rd(REG_VALVE_TIME);
        chk("first valve time", RST_PULSE_PERIOD, rdVal);
        for (i = 0; i < 4; i++) begin
            wr(REG_LEVEL_TWO_OFFSET, offTab[i]);
            expLvl = (offTab[i] <= OFFSET_UP_MAX) ? RST_LEVEL_ONE + offTab[i]
                : RST_LEVEL_ONE - offTab[i] + OFFSET_DOWN_BASE;
            pins(8'h50, 8'h40);
            cyc(8);
            chk("level two", expLvl, targetLevel);
            pins(8'h50, 8'h30);
            cyc(8);
            chk("level in band", expLvl, targetLevel);
            rd(REG_STATUS);
            chk("status level two", 8'h01, rdVal & 8'h01);
            pins(8'h50, 8'h20);
            cyc(8);
            chk("back to level one", RST_LEVEL_ONE, targetLevel);
        end
        wr(REG_OPTIONS, 8'h01 << OPT_NO_SPEED_LEVEL);
        pins(8'h50, 8'h40);
        cyc(8);
        chk("speed levelling off", RST_LEVEL_ONE, targetLevel);
        wr(REG_OPTIONS, 8'h00);
        wr(REG_LOWERING_PRESSURE, 8'h60);
        wr(REG_RAISING_PRESSURE, 8'h30);
        pins(8'h70, 8'h10);
        cyc(8);
        chk("auto lower", 8'h03, liftPair);
        pins(8'h20, 8'h10);
        cyc(8);
        chk("auto raise", 8'h02, liftPair);
        pins(8'h40, 8'h10);
        cmd(0);
        chk("manual lower slow", 8'h03, liftPair);
        cmd(1);
        chk("manual raise slow", 8'h02, liftPair);
        pins(8'h40, 8'h20);
        cmd(0);
        chk("manual lower fast", 8'h02, liftPair);
        wr(REG_SECOND_AXLE_SPEED, 8'h10);
        cmd(3);
        chk("second axle limit", 8'h00, liftPair);
        wr(REG_OPTIONS, 8'h01 << OPT_FULL_AUTO_LIFT);
        cmd(0);
        chk("full auto any speed", 8'h01, liftPair);
        pins(8'h40, 8'h10);
        wr(REG_TRACTION_HOME, 8'h02);
        wr(REG_TRACTION_OTHER, 8'h01);
        for (i = 0; i < 4; i++) begin
            dur = (i == 1) ? 2 : (i == 2) ? 1 : 0;
            wr(REG_OPTIONS, 8'(i));
            cmd(0);
            cmd(4);
            chk("traction start", 8'(dur != 0), {7'h0, tractionActive});
            if (dur != 0) begin
                chk("axles forced up", 8'h00, liftPair);
                cyc(dur * TRAC_CYC - 40);
                chk("traction running", 8'h01, {7'h0, tractionActive});
                cyc(80);
                chk("traction ended", 8'h00, {7'h0, tractionActive});
            end
        end
        wr(REG_OVER_PRESSURE, 8'h90);
        pins(8'ha0, 8'h10);
        cyc(8);
        chk("overpressure lowers", 8'h01, {7'h0, onBuffers});
        chk("lower valve held", 8'h01, {7'h0, valveLower});
        pins(8'h40, 8'h10);
        cyc(40);
        chk("overpressure held", 8'h01, {7'h0, onBuffers});
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(3);
        chk("overpressure cleared", 8'h00, {7'h0, onBuffers});
        rd(REG_OVER_PRESSURE);
        chk("limit after reset", RST_OVER_PRESSURE, rdVal);
        conclude();
    end
endmodule

// ==== tb/trailer_level_monitor.sv ====
/* Port checker for the trailer level control block.
   Assumes it is bound onto every instance and sees only its ports. */
`timescale 1ns/1ns
module trailer_level_monitor
    import trailer_level_pkg::*;
(
    // Clock, reset, register port
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    input wire logic [DATA_W-1:0] regRdData,
    // Pins
    input wire logic [7:0] pressureIn,
    input wire logic valveRaise,
    input wire logic liftAxleDown,
    input wire logic onBuffers,
    input wire logic tractionActive,
    input wire logic [7:0] targetLevel
);
    logic [7:0] lowerP_ff;
    logic [7:0] raiseP_ff;
    logic [7:0] overP_ff;

    // Thresholds shadowed from the write port, so no hierarchy peeking
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lowerP_ff <= RST_LOWERING_PRESSURE;
            raiseP_ff <= RST_RAISING_PRESSURE;
            overP_ff <= RST_OVER_PRESSURE;
        end else if (regWrStrobe) begin
            if (regAddr == REG_LOWERING_PRESSURE) lowerP_ff <= regWrData;
            if (regAddr == REG_RAISING_PRESSURE) raiseP_ff <= regWrData;
            if (regAddr == REG_OVER_PRESSURE) overP_ff <= regWrData;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_read_idle: assert property (!$past(regRdStrobe) |-> regRdData == 8'h00)
        else $error("read data not zero outside read slot");
    a_read_target: assert property ($past(regRdStrobe) && $past(regAddr) == REG_TARGET_LEVEL
        |-> regRdData == targetLevel) else $error("target read differs from pin");
    a_over_lower: assert property ((pressureIn > overP_ff) [*4] |-> ##[0:2] onBuffers)
        else $error("overpressure not latched");
    a_buffers_hold: assert property (onBuffers |=> onBuffers)
        else $error("overpressure latch dropped");
    a_buffers_noraise: assert property (onBuffers |-> !valveRaise)
        else $error("raise valve while on buffers");
    a_lift_lower: assert property ((pressureIn > lowerP_ff && !tractionActive) [*4]
        |-> ##[0:2] liftAxleDown) else $error("lift axle not lowered");
    a_lift_raise: assert property ((pressureIn < raiseP_ff && !onBuffers) [*4]
        |-> ##[0:2] !liftAxleDown) else $error("lift axle not raised");
    a_traction_up: assert property ((tractionActive && !onBuffers && pressureIn <= lowerP_ff) [*4]
        |-> !liftAxleDown) else $error("lift axle down during traction help");
    a_target_reset: assert property ($past(sys_rst, 2) && !$past(sys_rst)
        |-> ##[0:1] targetLevel == RST_LEVEL_ONE) else $error("target not level one after reset");
endmodule

bind trailer_level_ctrl trailer_level_monitor u_trailer_level_monitor (.clk(clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
    .regRdData(regRdData), .pressureIn(pressureIn), .valveRaise(valveRaise), .liftAxleDown(liftAxleDown),
    .onBuffers(onBuffers), .tractionActive(tractionActive), .targetLevel(targetLevel));
